// ===== rxwa_top.sv
// Receive word aligner: boundary restore, bit-slip, sync state machine, run length check, APB registers.
// Assumes the link clock and the deserializer word arrive from another domain; user strobes are on CLK_IN.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "rxwa_map.svh"

// Contract
// - Manual, bit-slip and automatic modes exist, pattern is 16 bits at 8-bit width and 7 or 10 at 10-bit, automatic only at 10-bit.
// - In manual mode the pattern-align enable from user logic governs the aligner at both widths.
// - At 8-bit width only rising edges of the enable seen after reset release count.
// - Each such edge starts a pattern search and the boundary moves where the pattern is found.
// - At 8-bit width later patterns at another boundary are ignored until the next rising edge.
// - At 10-bit width the pattern or its complement is searched while the enable is high and any new boundary is taken.
// - At 10-bit width with the enable low the present boundary is kept.
// - The erroneous group count that loses sync is programmable from 1 to 64.
// - The good group run that lowers the error count by one is programmable from 1 to 256.
// - In automatic mode the search for sync groups and pattern begins once reset is released; CTRL resets to manual, so it starts once CTRL is set to automatic.
// - Sync output rises after the programmed number of valid sync groups.
// - Sync output stays high until the programmed errors arrive without enough good groups between, then drops.
// - After loss the sync output stays low until the programmed valid sync groups are seen again.
// - Runs of equal bits are counted and the violation output rises when the threshold is reached.
// - The violation flag is made on link clock ticks and stays high for at least two of them.
// - The run threshold is 4 to 128 in steps of 4 at 8-bit width and 5 to 160 in steps of 5 at 10-bit.
module rxwa_top
    import rxwa_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic        LINK_CLK_IN,
    input  wire logic [9:0]  RX_DATA_IN,
    input  wire logic        ALIGN_EN_IN,
    input  wire logic        BITSLIP_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic      [9:0]  DATA_OUT,
    output logic             DATA_VALID_OUT,
    output logic             SYNC_OUT,
    output logic             RLV_OUT,
    output logic      [3:0]  BOUNDARY_OUT,
    output logic             IRQ_OUT
);
    // -----------------------------------------------------------------
    // Functions
    // -----------------------------------------------------------------
    function automatic logic pat_match(input logic [29:0] h, input logic [3:0] k,
                                       input logic w10, input logic len7, input logic [15:0] pat);
        logic [15:0] s16;
        logic [9:0]  s10;
        logic [9:0]  m;
        s16 = h[k +: 16];
        s10 = h[k +: 10];
        m   = len7 ? 10'h07f : 10'h3ff;
        if (!w10) begin
            pat_match = (s16 == pat);
        end else begin
            pat_match = ((s10 & m) == (pat[9:0] & m)) || ((~s10 & m) == (pat[9:0] & m));
        end
    endfunction : pat_match

    function automatic logic [3:0] ones10(input logic [9:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 10; i++) begin
            n = n + {3'h0, v[i]};
        end
        ones10 = n;
    endfunction : ones10

    function automatic logic [31:0] status_word(input logic sync, input logic rlv, input logic [3:0] bnd);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`RXWA_STAT_SYNC_BIT]      = sync;
        v[`RXWA_STAT_RLV_BIT]       = rlv;
        v[`RXWA_STAT_BND_LSB +: 4]  = bnd;
        status_word = v;
    endfunction : status_word

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    logic       lclk_s;
    logic [9:0] data_s;

    rxwa_sync #(.W(11)) u_sync (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .d_in     ({LINK_CLK_IN, RX_DATA_IN}),
        .q_out    ({lclk_s, data_s})
    );

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    rxwa_state_t s_q;
    rxwa_state_t s_d;

    rxwa_mode_t  mode;
    logic        w10;
    logic        len7;
    logic [3:0]  wmax;
    logic        tick;
    logic [29:0] hist_n;
    logic        found;
    logic [3:0]  fk;
    logic        may_align;
    logic [3:0]  nb;
    logic [9:0]  word_n;
    logic        at_bnd;
    logic        code_err;
    logic [7:0]  thr;
    logic [7:0]  run;
    logic        lastb;
    logic        viol;
    logic [3:0]  ev;
    logic        wr;
    logic        rd;
    logic        hit;
    logic [31:0] rdat;
    logic [3:0]  clr;
    logic [6:0]  loss_n;
    logic [3:0]  acq_n;
    logic [8:0]  good_n;

    always_comb begin
        s_d      = s_q;
        ev       = 4'h0;
        mode     = rxwa_mode_t'(s_q.ctrl[`RXWA_CTRL_MODE_LSB +: 2]);
        // Automatic mode forces 10-bit width
        w10      = s_q.ctrl[`RXWA_CTRL_W10_BIT] || (mode == RXWA_AUTO);
        len7     = s_q.ctrl[`RXWA_CTRL_LEN7_BIT];
        wmax     = w10 ? 4'h9 : 4'h7;
        loss_n   = {1'b0, s_q.scfg[`RXWA_SCFG_LOSS_LSB +: 6]} + 7'h01;
        acq_n    = s_q.scfg[`RXWA_SCFG_ACQ_LSB +: 4];
        good_n   = {1'b0, s_q.scfg[`RXWA_SCFG_GOOD_LSB +: 8]} + 9'h001;
        thr      = 8'((9'({4'h0, s_q.rcfg} + 9'h001)) * (w10 ? `RXWA_STEP_W10 : `RXWA_STEP_W8));
        tick     = lclk_s && !s_q.lclk;
        s_d.lclk = lclk_s;
        s_d.dv   = tick;

        // -----------------------------------------------------------------
        // Word history and pattern search
        // -----------------------------------------------------------------
        hist_n = w10 ? {data_s, s_q.hist[29:10]} : {6'h00, data_s[7:0], s_q.hist[23:8]};
        found  = 1'b0;
        fk     = s_q.bnd;
        for (int k = 9; k >= 0; k--) begin
            if (4'(k) <= wmax && pat_match(hist_n, 4'(k), w10, len7, s_q.pat)) begin
                found = 1'b1;
                fk    = 4'(k);
            end
        end

        // Held-high enable across reset release is not an edge
        s_d.en_prev = ALIGN_EN_IN;
        if (mode == RXWA_MANUAL && !w10 && ALIGN_EN_IN && !s_q.en_prev) begin
            s_d.arm = 1'b1;
        end

        unique case (mode)
            RXWA_MANUAL: may_align = w10 ? ALIGN_EN_IN : s_q.arm;
            RXWA_AUTO:   may_align = (s_q.sst == RXWA_LOSS);
            default:     may_align = 1'b0;
        endcase

        nb = s_q.bnd;
        if (tick && may_align && found) begin
            nb = fk;
            if (fk != s_q.bnd) begin
                ev[`RXWA_INT_REALIGN] = 1'b1;
            end
            if (!w10) begin
                s_d.arm = 1'b0;
            end
        end
        // A slip overrides a pattern hit in the same cycle
        if (mode == RXWA_BITSLIP && BITSLIP_IN) begin
            nb = (s_q.bnd >= wmax) ? 4'h0 : s_q.bnd + 4'h1;
            ev[`RXWA_INT_REALIGN] = 1'b1;
        end
        s_d.bnd = nb;

        // Errors show two ticks late: the word comes from history
        word_n   = w10 ? hist_n[nb +: 10] : {2'b00, hist_n[nb +: 8]};
        at_bnd   = pat_match(hist_n, nb, w10, len7, s_q.pat);
        // Without a code-group decoder, a disparity outside 4..6 ones marks a bad group
        code_err = (ones10(word_n) < `RXWA_DISP_MIN) || (ones10(word_n) > `RXWA_DISP_MAX);
        if (tick) begin
            s_d.hist = hist_n;
            s_d.word = word_n;
        end

        // -----------------------------------------------------------------
        // Synchronisation state machine
        // -----------------------------------------------------------------
        // Boundary frozen once in sync; only loss reopens search
        if (mode != RXWA_AUTO) begin
            s_d.sst  = RXWA_LOSS;
            s_d.gcnt = 4'h0;
        end else if (tick) begin
            unique case (s_q.sst)
                RXWA_LOSS: begin
                    if (at_bnd) begin
                        s_d.gcnt = s_q.gcnt + 4'h1;
                        if (s_q.gcnt + 4'h1 >= acq_n) begin
                            s_d.sst  = RXWA_SYNC;
                            s_d.gcnt = 4'h0;
                            s_d.ecnt = 7'h00;
                            s_d.grun = 9'h000;
                            ev[`RXWA_INT_ACQ] = 1'b1;
                        end
                    end
                end
                RXWA_SYNC: begin
                    if (code_err) begin
                        s_d.grun = 9'h000;
                        s_d.ecnt = s_q.ecnt + 7'h01;
                        if (s_q.ecnt + 7'h01 >= loss_n) begin
                            s_d.sst  = RXWA_LOSS;
                            s_d.ecnt = 7'h00;
                            ev[`RXWA_INT_LOST] = 1'b1;
                        end
                    end else if (s_q.grun + 9'h001 >= good_n) begin
                        s_d.grun = 9'h000;
                        if (s_q.ecnt != 7'h00) begin
                            s_d.ecnt = s_q.ecnt - 7'h01;
                        end
                    end else begin
                        s_d.grun = s_q.grun + 9'h001;
                    end
                end
                default: s_d.sst = RXWA_LOSS;
            endcase
        end

        // -----------------------------------------------------------------
        // Run length check on raw link bits
        // -----------------------------------------------------------------
        // Runs span word edges, so the last bit is kept
        run   = s_q.run;
        lastb = s_q.last_bit;
        viol  = 1'b0;
        for (int i = 0; i < 10; i++) begin
            if (w10 || i < 8) begin
                if (data_s[i] == lastb) begin
                    run = (run == 8'hff) ? run : run + 8'h01;
                end else begin
                    run = 8'h01;
                end
                lastb = data_s[i];
                if (run >= thr) begin
                    viol = 1'b1;
                end
            end
        end
        if (tick) begin
            s_d.run      = run;
            s_d.last_bit = lastb;
            if (viol) begin
                s_d.hold = `RXWA_RLV_HOLD;
                ev[`RXWA_INT_RLV] = 1'b1;
            end else if (s_q.hold != 2'h0) begin
                s_d.hold = s_q.hold - 2'h1;
            end
        end
        // Stretched over link ticks so slower fabric clocks still catch it
        s_d.rlv = (s_d.hold != 2'h0);

        // -----------------------------------------------------------------
        // APB slave, one wait state
        // -----------------------------------------------------------------
        wr   = PSEL_IN && PENABLE_IN && s_q.pready && PWRITE_IN;
        rd   = PSEL_IN && PENABLE_IN && !s_q.pready;
        hit  = 1'b1;
        rdat = 32'h0000_0000;
        unique case (PADDR_IN)
            `RXWA_OFS_CTRL:     rdat = {28'h0, s_q.ctrl};
            `RXWA_OFS_PATTERN:  rdat = {16'h0, s_q.pat};
            `RXWA_OFS_SYNC_CFG: rdat = {8'h0, s_q.scfg};
            `RXWA_OFS_RLV_CFG:  rdat = {27'h0, s_q.rcfg};
            `RXWA_OFS_STATUS:   rdat = status_word(s_q.sst == RXWA_SYNC, s_q.rlv, s_q.bnd);
            `RXWA_OFS_INT_STAT: rdat = {28'h0, s_q.ist};
            `RXWA_OFS_INT_MASK: rdat = {28'h0, s_q.imsk};
            default:            hit  = 1'b0;
        endcase
        // Read data zero outside the ready cycle
        s_d.pready  = rd;
        s_d.pslverr = rd && !hit;
        s_d.prdata  = (rd && !PWRITE_IN) ? rdat : 32'h0000_0000;

        // -----------------------------------------------------------------
        // Register writes
        // -----------------------------------------------------------------
        clr = 4'h0;
        if (wr) begin
            unique case (PADDR_IN)
                `RXWA_OFS_CTRL:     s_d.ctrl = PWDATA_IN[3:0];
                `RXWA_OFS_PATTERN:  s_d.pat  = PWDATA_IN[15:0];
                `RXWA_OFS_SYNC_CFG: s_d.scfg = PWDATA_IN[23:0];
                `RXWA_OFS_RLV_CFG:  s_d.rcfg = PWDATA_IN[4:0];
                `RXWA_OFS_INT_STAT: clr      = PWDATA_IN[3:0];
                `RXWA_OFS_INT_MASK: s_d.imsk = PWDATA_IN[3:0];
                default:            clr      = 4'h0;
            endcase
        end
        // A new event beats a clear in the same cycle
        s_d.ist = (s_q.ist & ~clr) | ev;
        s_d.irq = |(s_d.ist & s_d.imsk);
    end

    // Whole state in one register; reset values from the map
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            s_q         <= '0;
            s_q.en_prev <= 1'b1;
            s_q.sst     <= RXWA_LOSS;
            s_q.ctrl    <= `RXWA_CTRL_RST;
            s_q.pat     <= `RXWA_PAT_RST;
            s_q.scfg    <= `RXWA_SCFG_RST;
            s_q.rcfg    <= `RXWA_RCFG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign PRDATA_OUT     = s_q.prdata;
    assign PREADY_OUT     = s_q.pready;
    assign PSLVERR_OUT    = s_q.pslverr;
    assign DATA_OUT       = s_q.word;
    assign DATA_VALID_OUT = s_q.dv;
    assign SYNC_OUT       = (s_q.sst == RXWA_SYNC);
    assign RLV_OUT        = s_q.rlv;
    assign BOUNDARY_OUT   = s_q.bnd;
    assign IRQ_OUT        = s_q.irq;

endmodule : rxwa_top

// ===== rxwa_map.svh
// Register map, field positions and fixed counts of the receive word aligner.
// Assumes byte addresses on a 32-bit APB; included by bare name.
`ifndef RXWA_MAP_SVH
`define RXWA_MAP_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define RXWA_OFS_CTRL      8'h00
`define RXWA_OFS_PATTERN   8'h04
`define RXWA_OFS_SYNC_CFG  8'h08
`define RXWA_OFS_RLV_CFG   8'h0c
`define RXWA_OFS_STATUS    8'h10
`define RXWA_OFS_INT_STAT  8'h14
`define RXWA_OFS_INT_MASK  8'h18

// -----------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------
`define RXWA_CTRL_MODE_LSB 0
`define RXWA_CTRL_W10_BIT  2
`define RXWA_CTRL_LEN7_BIT 3
`define RXWA_CTRL_RST      4'h4
`define RXWA_PAT_RST       16'h017c
`define RXWA_SCFG_LOSS_LSB 0
`define RXWA_SCFG_ACQ_LSB  8
`define RXWA_SCFG_GOOD_LSB 16
`define RXWA_SCFG_RST      24'h0f_03_03
`define RXWA_RCFG_RST      5'h1f
`define RXWA_STEP_W8       8'h04
`define RXWA_STEP_W10      8'h05
`define RXWA_RLV_HOLD      2'h2
`define RXWA_DISP_MIN      4'h4
`define RXWA_DISP_MAX      4'h6
`define RXWA_INT_ACQ       0
`define RXWA_INT_LOST      1
`define RXWA_INT_RLV       2
`define RXWA_INT_REALIGN   3
`define RXWA_STAT_SYNC_BIT 0
`define RXWA_STAT_RLV_BIT  1
`define RXWA_STAT_BND_LSB  8

`endif

// ===== rxwa_pkg.sv
// Types of the receive word aligner.
// Assumes rxwa_map.svh for the numeric constants.
package rxwa_pkg;

    typedef enum logic [1:0] {RXWA_MANUAL, RXWA_BITSLIP, RXWA_AUTO, RXWA_RSVD} rxwa_mode_t;
    typedef enum logic [1:0] {RXWA_LOSS, RXWA_SYNC} rxwa_sync_t;

    typedef struct packed {
        logic        lclk;
        logic        en_prev;
        logic        arm;
        logic [29:0] hist;
        logic [3:0]  bnd;
        logic [9:0]  word;
        logic        dv;
        rxwa_sync_t  sst;
        logic [3:0]  gcnt;
        logic [6:0]  ecnt;
        logic [8:0]  grun;
        logic [7:0]  run;
        logic        last_bit;
        logic [1:0]  hold;
        logic        rlv;
        logic [3:0]  ctrl;
        logic [15:0] pat;
        logic [23:0] scfg;
        logic [4:0]  rcfg;
        logic [3:0]  ist;
        logic [3:0]  imsk;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
    } rxwa_state_t;

endpackage : rxwa_pkg

// ===== rxwa_sync.sv
// Two-flop synchroniser for levels arriving from another clock domain.
// Assumes the bits of the bus are sampled by their own source clock.
`timescale 1ns/1ps
module rxwa_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : rxwa_sync

// ===== rxwa_checker.sv
// Port-level checks of the receive word aligner, bound into rxwa_top.
// Assumes one clock domain, CLK_IN, with RST_B_IN as asynchronous active-low reset.
`timescale 1ns/1ps
module rxwa_checker (
    input wire logic        CLK_IN,
    input wire logic        RST_B_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic        BITSLIP_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        DATA_VALID_OUT,
    input wire logic        SYNC_OUT,
    input wire logic        RLV_OUT,
    input wire logic [3:0]  BOUNDARY_OUT
);
    // Link ticks seen while the violation flag stands; saturates so it never wraps
    logic [2:0] vt_q;
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            vt_q <= 3'h0;
        end else if (!RLV_OUT) begin
            vt_q <= 3'h0;
        end else if (DATA_VALID_OUT && vt_q != 3'h7) begin
            vt_q <= vt_q + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    a_ready_follows: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
        else $error("no ready after access");
    a_ready_single: assert property (PREADY_OUT |-> $past(PENABLE_IN) && $past(PSEL_IN) ##1 !PREADY_OUT)
        else $error("ready without access or too long");
    a_err_quiet: assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0)
        else $error("error beat malformed");
    a_rdata_idle: assert property (!PREADY_OUT || PWRITE_IN |-> PRDATA_OUT == 32'h0)
        else $error("read data outside read beat");
    a_tick_spacing: assert property (DATA_VALID_OUT |=> !DATA_VALID_OUT [*8])
        else $error("valid pulses too close");
    a_sync_on_tick: assert property ($rose(SYNC_OUT) |-> DATA_VALID_OUT)
        else $error("sync rose off a link tick");
    a_rlv_hold: assert property ($fell(RLV_OUT) |-> vt_q >= 3'h2)
        else $error("violation flag too short");
    a_bnd_range: assert property (BOUNDARY_OUT <= 4'h9)
        else $error("boundary out of range");

    c_sync: cover property ($rose(SYNC_OUT));
    c_rlv: cover property ($rose(RLV_OUT));
    c_slverr: cover property (PSLVERR_OUT);
    c_slip: cover property (BITSLIP_IN);
endmodule : rxwa_checker

bind rxwa_top rxwa_checker u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .BITSLIP_IN(BITSLIP_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .DATA_VALID_OUT(DATA_VALID_OUT), .SYNC_OUT(SYNC_OUT), .RLV_OUT(RLV_OUT),
    .BOUNDARY_OUT(BOUNDARY_OUT));

// ===== rxwa_deser_model.sv
// Deserializer stand-in: free-running recovered clock, one parallel word per rising edge.
// Assumes the bench changes the next word well between link edges.
`timescale 1ns/1ps
module rxwa_deser_model (
    input  wire logic [9:0] word_in,
    output logic            link_clk_out,
    output logic      [9:0] data_out
);
    // Odd start offset keeps link edges out of step with the system clock
    initial begin
        link_clk_out = 1'b0;
        data_out     = 10'h000;
        #3.3;
        forever #62.5 link_clk_out = ~link_clk_out;
    end

    always @(posedge link_clk_out) begin
        data_out <= word_in;
    end
endmodule : rxwa_deser_model

// ===== tb.sv
// Self-checking bench of the receive word aligner: registers, alignment modes, sync machine, run length.
// Assumes rxwa_top, the deserializer model and the bound checker are compiled before it.
`timescale 1ns/1ps
`include "rxwa_map.svh"
module tb;
    import rxwa_pkg::*;
    localparam logic [15:0] P16 = `RXWA_PAT_RST;
    localparam logic [9:0]  P   = P16[9:0];
    logic        clk, rst_b, align_en, bitslip, psel, penable, pwrite, link_clk;
    logic        pready, pslverr, dv, sync, rlv, irq, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [9:0]  wrd, rx, dout;
    logic [3:0]  bnd;
    int          err_total = 0;
    int          n_tests = 0;
    int          k1, k2, b0;

    rxwa_top DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .LINK_CLK_IN(link_clk), .RX_DATA_IN(rx),
        .ALIGN_EN_IN(align_en), .BITSLIP_IN(bitslip), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .DATA_OUT(dout), .DATA_VALID_OUT(dv),
        .SYNC_OUT(sync), .RLV_OUT(rlv), .BOUNDARY_OUT(bnd), .IRQ_OUT(irq));
    rxwa_deser_model PEER (.word_in(wrd), .link_clk_out(link_clk), .data_out(rx));

    function automatic logic [9:0] rot10(input logic [9:0] w, input int k);
        logic [19:0] t;
        t = {w, w} << k;
        return t[19:10];
    endfunction : rot10

    function automatic logic [15:0] rot16(input logic [15:0] w, input int k);
        logic [31:0] t;
        t = {w, w} << k;
        return t[31:16];
    endfunction : rot16

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s: got %h want %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic hang(input string m);
        err_total++;
        $display("BAD %0t %s: no answer", $time, m);
        conclude();
    endtask : hang

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 40) hang("apb");
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk(r, x, "read data");
        chk(e, xe, "read error");
    endtask : rd

    // One word per link tick; returns once the aligner has answered it
    task automatic send(input logic [9:0] w, input int n);
        int i;
        repeat (n) begin
            @(posedge clk);
            wrd <= w;
            for (i = 0; i < 60; i++) begin
                @(posedge clk);
                if (dv === 1'b1) break;
            end
            if (i == 60) hang("link");
        end
    endtask : send

    task automatic pairs(input int k, input int n);
        logic [15:0] s;
        s = rot16(P16, k);
        repeat (n) begin
            send({2'b00, s[7:0]}, 1);
            send({2'b00, s[15:8]}, 1);
        end
    endtask : pairs

    task automatic align(input logic v);
        @(posedge clk);
        align_en <= v;
    endtask : align

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        {rst_b, align_en, bitslip, psel, penable, pwrite, paddr, pwdata, wrd} = '0;
        void'($urandom(48614));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk({sync, rlv, irq, dv, pready, bnd}, 32'h0, "reset outputs");
        rd(`RXWA_OFS_CTRL, `RXWA_CTRL_RST, 1'b0);
        rd(`RXWA_OFS_PATTERN, `RXWA_PAT_RST, 1'b0);
        rd(`RXWA_OFS_SYNC_CFG, `RXWA_SCFG_RST, 1'b0);
        rd(`RXWA_OFS_RLV_CFG, `RXWA_RCFG_RST, 1'b0);
        rd(8'h1c, 32'h0, 1'b1);
        apb(1'b1, `RXWA_OFS_STATUS, 32'hffffffff);
        chk(e, 1'b0, "status write");
        $display("test registers done");

        k1 = $urandom_range(9, 0);
        k2 = (k1 + 1 + $urandom_range(7, 0)) % 10;
        align(1'b1);
        send(rot10(P, k1), 5);
        chk(bnd, k1, "pattern boundary");
        chk(dout, P, "aligned word");
        send(rot10(~P, k2), 5);
        chk(bnd, k2, "complement boundary");
        align(1'b0);
        send(rot10(P, k1), 5);
        chk(bnd, k2, "boundary held");
        $display("test manual wide done");

        apb(1'b1, `RXWA_OFS_CTRL, 32'h0);
        k1 = $urandom_range(15, 0);
        k2 = (k1 + 3) % 16;
        // Flush old words with the enable low
        pairs(k1, 2);
        align(1'b1);
        pairs(k1, 4);
        chk(bnd, k1 % 8, "edge realign");
        pairs(k2, 4);
        chk(bnd, k1 % 8, "no new edge");
        align(1'b0);
        align(1'b1);
        pairs(k2, 4);
        chk(bnd, k2 % 8, "second edge");
        align(1'b0);
        $display("test manual narrow done");

        apb(1'b1, `RXWA_OFS_CTRL, 32'h1);
        b0 = bnd;
        for (k1 = 1; k1 <= 9; k1++) begin
            @(posedge clk);
            bitslip <= 1'b1;
            @(posedge clk);
            bitslip <= 1'b0;
            repeat (3) @(posedge clk);
            chk(bnd, (b0 + k1) % 8, "slip step");
        end
        $display("test bit slip done");

        // Two errors lose sync, one good group repays one error, eight groups acquire
        apb(1'b1, `RXWA_OFS_SYNC_CFG, 32'h000801);
        apb(1'b1, `RXWA_OFS_CTRL, 32'h2);
        send(P, 12);
        chk(sync, 1'b1, "acquired");
        repeat (6) begin
            send(10'h000, 1);
            send(P, 1);
        end
        send(P, 3);
        chk(sync, 1'b1, "errors repaid");
        send(10'h000, 2);
        send(P, 3);
        chk(sync, 1'b0, "lost");
        send(P, 4);
        chk(sync, 1'b0, "still searching");
        send(P, 5);
        chk(sync, 1'b1, "reacquired");
        rd(`RXWA_OFS_STATUS, 32'h1, 1'b0);
        $display("test auto sync done");

        apb(1'b1, `RXWA_OFS_CTRL, 32'h4);
        apb(1'b1, `RXWA_OFS_RLV_CFG, 32'h1);
        apb(1'b1, `RXWA_OFS_INT_STAT, 32'hf);
        send(10'h155, 3);
        send(10'h1ff, 1);
        send(10'h2aa, 2);
        chk(rlv, 1'b0, "run of nine");
        send(10'h1ff, 1);
        chk(rlv, 1'b1, "run of ten");
        apb(1'b0, `RXWA_OFS_INT_STAT, 32'h0);
        chk(r[`RXWA_INT_RLV], 1'b1, "violation event");
        chk(irq, 1'b0, "masked");
        apb(1'b1, `RXWA_OFS_INT_MASK, 32'h4);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1, "unmasked");
        send(10'h155, 4);
        chk(rlv, 1'b0, "violation over");
        apb(1'b1, `RXWA_OFS_INT_STAT, 32'h4);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0, "cleared");
        $display("test run length done");

        apb(1'b1, `RXWA_OFS_CTRL, 32'hc);
        k1 = $urandom_range(9, 1);
        align(1'b1);
        send(rot10(P ^ 10'h380, k1), 5);
        chk(bnd, k1, "short pattern");
        align(1'b0);
        $display("test short pattern done");
        conclude();
    end
endmodule : tb
